//--- core/rtc_core.v
// rtc timekeeping core: calendar, alarm and wakeup countdown timer
// assumes osc32kTick is a one-cycle pulse at 32.768 kHz, synchronous to ref_clk,
// and a simple synchronous register port from the serial front end
`timescale 1ns/1ps
`include "rtc_regs.vh"

module rtc_core #(
   parameter TMR_W = 24
) (
   // clock and reset
   input  wire       ref_clk,
   input  wire       nrst,
   // oscillator tick
   input  wire       osc32kTick,
   // register port
   input  wire       regWr,
   input  wire       regRd,
   input  wire [4:0] regAddr,
   input  wire [7:0] regWrData,
   output wire [7:0] regRdData,
   // interrupt pin, active low
   output wire       intN
);

   reg  [`DIV_W-1:0] div_reg;
   reg  [7:0]        week_reg;
   reg  [7:0]        almMin_reg;
   reg  [7:0]        almHour_reg;
   reg  [7:0]        almWd_reg;
   reg  [TMR_W-1:0]  preset_reg;
   reg  [TMR_W-1:0]  tmrCnt_reg;
   reg  [7:0]        ctrl1_reg;
   reg  [7:0]        ctrl2_reg;
   reg               halt_reg;
   reg               restart_reg;
   reg               runEnPrev_reg;
   reg               minDone_reg;
   reg               almFlag_reg;
   reg               tmrFlag_reg;
   reg               updFlag_reg;
   reg               lowHist_reg;
   reg               supDrop_reg;
   reg  [7:0]        rdData_reg;
   reg               intN_reg;
   reg  [7:0]        rdData_next;
   reg  [7:0]        dateMax;
   reg               tmrTick;
   wire [7:0]        secCnt, minCnt, hourCnt, dateCnt, monCnt, yearCnt;
   wire              secCarry, minCarry, hourCarry, dateCarry, monCarry;
   wire              secTick, tick4096, tick64, leapYear, wrSec, wrFlags, preClr;
   wire              almHit, almMinOk, almHourOk, almDayOk;
   wire              tmrRun, tmrLoad, tmrZero, tmrEvt, updEvt;

   // decoded writes of the strobed register port
   assign wrSec   = regWr && (regAddr == `OFS_SEC);
   assign wrFlags = regWr && (regAddr == `OFS_FLAGS);
   assign preClr  = regWr && (regAddr == `OFS_CTRL2) && regWrData[`BIT_PRE_CLR];

   // 32.768 kHz divider chain, one second per full wrap
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         div_reg <= {`DIV_W{1'b0}};
      end else if (preClr) begin
         // clear of every stage 16384 Hz down to 1 Hz
         div_reg <= {`DIV_W{1'b0}};
      end else if (wrSec) begin
         // only the 512 Hz to 2 Hz stages restart; faster stages and 1 Hz stage kept
         div_reg[`DIV_SUB_HI:`DIV_SUB_LO] <= {(`DIV_SUB_HI-`DIV_SUB_LO+1){1'b0}};
      end else if (osc32kTick) begin
         div_reg <= div_reg + {{(`DIV_W-1){1'b0}}, 1'b1};
      end
   end

   // second update and countdown source ticks from the chain
   assign secTick  = osc32kTick && (&div_reg) && !preClr && !wrSec;
   assign tick4096 = osc32kTick && (&div_reg[`DIV_4096_MSB:0]);
   assign tick64   = osc32kTick && (&div_reg[`DIV_64_MSB:0]);

   // leap year: tens*10+ones divisible by four, in bcd form
   assign leapYear = ((yearCnt[1:0] + {yearCnt[4], 1'b0}) & 2'b11) == 2'b00;

   // month length picks the date limit
   always @* begin
      if (monCnt == `MONTH_FEB) begin
         dateMax = leapYear ? `DAYS_FEB_LP : `DAYS_FEB;
      end else if (monCnt == 8'h04 || monCnt == 8'h06 ||
                   monCnt == 8'h09 || monCnt == 8'h11) begin
         dateMax = `DAYS_SHORT;
      end else begin
         dateMax = `DAYS_LONG;
      end
   end

   // seconds; a loaded 60 sits above the limit and wraps to 00 next
   bcd_counter #(.RST_VAL(`RST_ZERO), .WRAP_VAL(`RST_ZERO)) secCounter (
      .clk     (ref_clk),
      .rstN    (nrst),
      .load    (wrSec),
      .loadVal (regWrData & `MASK_SEC),
      .step    (secTick),
      .maxVal  (`MAX_SEC),
      .count   (secCnt),
      .carry   (secCarry)
   );

   // minutes
   bcd_counter #(.RST_VAL(`RST_ZERO), .WRAP_VAL(`RST_ZERO)) minCounter (
      .clk     (ref_clk),
      .rstN    (nrst),
      .load    (regWr && (regAddr == `OFS_MIN)),
      .loadVal (regWrData & `MASK_MIN),
      .step    (secCarry),
      .maxVal  (`MAX_MIN),
      .count   (minCnt),
      .carry   (minCarry)
   );

   // hours, 24-hour only
   bcd_counter #(.RST_VAL(`RST_ZERO), .WRAP_VAL(`RST_ZERO)) hourCounter (
      .clk     (ref_clk),
      .rstN    (nrst),
      .load    (regWr && (regAddr == `OFS_HOUR)),
      .loadVal (regWrData & `MASK_HOUR),
      .step    (minCarry),
      .maxVal  (`MAX_HOUR),
      .count   (hourCnt),
      .carry   (hourCarry)
   );

   // date of month
   bcd_counter #(.RST_VAL(`RST_ONE), .WRAP_VAL(`RST_ONE)) dateCounter (
      .clk     (ref_clk),
      .rstN    (nrst),
      .load    (regWr && (regAddr == `OFS_DATE)),
      .loadVal (regWrData & `MASK_DATE),
      .step    (hourCarry),
      .maxVal  (dateMax),
      .count   (dateCnt),
      .carry   (dateCarry)
   );

   // month
   bcd_counter #(.RST_VAL(`RST_ONE), .WRAP_VAL(`RST_ONE)) monCounter (
      .clk     (ref_clk),
      .rstN    (nrst),
      .load    (regWr && (regAddr == `OFS_MONTH)),
      .loadVal (regWrData & `MASK_MONTH),
      .step    (dateCarry),
      .maxVal  (`MAX_MONTH),
      .count   (monCnt),
      .carry   (monCarry)
   );

   // year, no century bit
   bcd_counter #(.RST_VAL(`RST_ZERO), .WRAP_VAL(`RST_ZERO)) yearCounter (
      .clk     (ref_clk),
      .rstN    (nrst),
      .load    (regWr && (regAddr == `OFS_YEAR)),
      .loadVal (regWrData & `MASK_YEAR),
      .step    (monCarry),
      .maxVal  (`MAX_YEAR),
      .count   (yearCnt),
      .carry   ()
   );

   // weekday rotates on the day carry; a bad pattern just rotates as-is
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         week_reg <= `RST_ONE;
      end else if (regWr && (regAddr == `OFS_WEEK)) begin
         week_reg <= regWrData & `MASK_WEEK;
      end else if (hourCarry) begin
         week_reg <= {1'b0, week_reg[5:0], week_reg[6]};
      end
   end

   // alarm targets and control registers
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         almMin_reg  <= `RST_ZERO;
         almHour_reg <= `RST_ZERO;
         almWd_reg   <= `RST_ZERO;
         preset_reg  <= {TMR_W{1'b0}};
         ctrl1_reg   <= `RST_CTRL1;
         ctrl2_reg   <= `RST_CTRL2;
         halt_reg    <= 1'b0;
         restart_reg <= 1'b0;
      end else if (regWr) begin
         if (regAddr == `OFS_ALM_MIN) begin
            almMin_reg <= regWrData;
         end else if (regAddr == `OFS_ALM_HOUR) begin
            almHour_reg <= regWrData;
         end else if (regAddr == `OFS_ALM_WD) begin
            almWd_reg <= regWrData;
         end else if (regAddr == `OFS_PRE_LO) begin
            preset_reg[7:0] <= regWrData;
         end else if (regAddr == `OFS_PRE_MID) begin
            preset_reg[15:8] <= regWrData;
         end else if (regAddr == `OFS_PRE_HI) begin
            preset_reg[23:16] <= regWrData;
         end else if (regAddr == `OFS_CTRL1) begin
            ctrl1_reg <= regWrData;
         end else if (regAddr == `OFS_CTRL2) begin
            // bits 2:0 are the fixed zeros and the self-clearing clear bit
            ctrl2_reg <= {regWrData[7:3], 3'b000};
         end else if (regAddr == `OFS_TMR_RUN) begin
            halt_reg    <= regWrData[`BIT_HALT];
            restart_reg <= regWrData[`BIT_RESTART];
         end
      end
   end

   // alarm compare; a field with its enable low is a don't-care
   assign almMinOk  = !almMin_reg[`BIT_FLD_EN] || (almMin_reg[6:0] == minCnt[6:0]);
   assign almHourOk = !almHour_reg[`BIT_FLD_EN] || (almHour_reg[5:0] == hourCnt[5:0]);
   assign almDayOk  = !almWd_reg[`BIT_FLD_EN] ||
                      (ctrl1_reg[`BIT_WD_SEL] ? (almWd_reg[5:0] == dateCnt[5:0])
                                            : |(almWd_reg[6:0] & week_reg[6:0]));
   // compared once per minute, one cycle after the counters moved
   assign almHit = minDone_reg && almMinOk && almHourOk && almDayOk;

   // countdown source select
   always @* begin
      case (ctrl1_reg[1:0])
         `TSRC_4096: tmrTick = tick4096;
         `TSRC_64:   tmrTick = tick64;
         `TSRC_SEC:  tmrTick = secTick;
         default:    tmrTick = secCarry;
      endcase
   end

   // one-shot countdown; enable edge or restart reloads the preset
   assign tmrRun  = ctrl1_reg[`BIT_RUN_EN] && !halt_reg;
   assign tmrLoad = (ctrl1_reg[`BIT_RUN_EN] && !runEnPrev_reg) ||
                    (regWr && (regAddr == `OFS_TMR_RUN) && regWrData[`BIT_RESTART]);
   assign tmrZero = (tmrCnt_reg == {TMR_W{1'b0}});
   assign tmrEvt  = tmrRun && tmrTick && !tmrLoad &&
                    (tmrCnt_reg == {{(TMR_W-1){1'b0}}, 1'b1});

   // timer count and edge history
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tmrCnt_reg    <= {TMR_W{1'b0}};
         runEnPrev_reg <= 1'b0;
         minDone_reg   <= 1'b0;
      end else begin
         runEnPrev_reg <= ctrl1_reg[`BIT_RUN_EN];
         // the seconds carry is the minute update, whatever the update select
         minDone_reg   <= secCarry;
         if (tmrLoad) begin
            tmrCnt_reg <= preset_reg;
         end else if (tmrRun && tmrTick && !tmrZero) begin
            tmrCnt_reg <= tmrCnt_reg - {{(TMR_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // update event: each second or each minute
   assign updEvt = ctrl1_reg[`BIT_UPD_MIN] ? secCarry : secTick;

   // sticky flags: a written zero clears, a one keeps, set wins
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         almFlag_reg <= 1'b0;
         tmrFlag_reg <= 1'b0;
         updFlag_reg <= 1'b0;
         lowHist_reg <= 1'b1;
         supDrop_reg <= 1'b1;
      end else begin
         almFlag_reg <= almHit ||
                        (almFlag_reg && !(wrFlags && !regWrData[`BIT_ALM_FLG]));
         tmrFlag_reg <= tmrEvt ||
                        (tmrFlag_reg && !(wrFlags && !regWrData[`BIT_CNT_FLG]));
         updFlag_reg <= updEvt ||
                        (updFlag_reg && !(wrFlags && !regWrData[`BIT_UPD_FLG]));
         lowHist_reg <= lowHist_reg && !(wrFlags && !regWrData[`BIT_LOW_HIST]);
         supDrop_reg <= supDrop_reg && !(wrFlags && !regWrData[`BIT_SUP_DROP]);
      end
   end

   // read mux; unmapped offsets read zero
   always @* begin
      rdData_next = 8'h00;
      if (regAddr == `OFS_SEC) begin
         rdData_next = secCnt & `MASK_SEC;
      end else if (regAddr == `OFS_MIN) begin
         rdData_next = minCnt & `MASK_MIN;
      end else if (regAddr == `OFS_HOUR) begin
         rdData_next = hourCnt & `MASK_HOUR;
      end else if (regAddr == `OFS_WEEK) begin
         rdData_next = week_reg & `MASK_WEEK;
      end else if (regAddr == `OFS_DATE) begin
         rdData_next = dateCnt & `MASK_DATE;
      end else if (regAddr == `OFS_MONTH) begin
         rdData_next = monCnt & `MASK_MONTH;
      end else if (regAddr == `OFS_YEAR) begin
         rdData_next = yearCnt;
      end else if (regAddr == `OFS_ALM_MIN) begin
         rdData_next = almMin_reg;
      end else if (regAddr == `OFS_ALM_HOUR) begin
         rdData_next = almHour_reg;
      end else if (regAddr == `OFS_ALM_WD) begin
         rdData_next = almWd_reg;
      end else if (regAddr == `OFS_PRE_LO) begin
         rdData_next = preset_reg[7:0];
      end else if (regAddr == `OFS_PRE_MID) begin
         rdData_next = preset_reg[15:8];
      end else if (regAddr == `OFS_PRE_HI) begin
         rdData_next = preset_reg[23:16];
      end else if (regAddr == `OFS_CTRL1) begin
         rdData_next = ctrl1_reg;
      end else if (regAddr == `OFS_FLAGS) begin
         rdData_next = {2'b00, updFlag_reg, tmrFlag_reg, almFlag_reg,
                        1'b0, lowHist_reg, supDrop_reg};
      end else if (regAddr == `OFS_CTRL2) begin
         rdData_next = ctrl2_reg;
      end else if (regAddr == `OFS_TMR_RUN) begin
         rdData_next = {halt_reg, restart_reg, 6'h00};
      end else if (regAddr == `OFS_CNT_LO) begin
         rdData_next = tmrCnt_reg[7:0];
      end else if (regAddr == `OFS_CNT_MID) begin
         rdData_next = tmrCnt_reg[15:8];
      end else if (regAddr == `OFS_CNT_HI) begin
         rdData_next = tmrCnt_reg[23:16];
      end
   end

   // registered read data and interrupt pin
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rdData_reg <= 8'h00;
         intN_reg   <= 1'b1;
      end else begin
         if (regRd) begin
            rdData_reg <= rdData_next;
         end
         // pin stays low while any enabled flag stands
         intN_reg <= !((almFlag_reg && ctrl2_reg[`BIT_ALM_IEN]) ||
                       (tmrFlag_reg && ctrl2_reg[`BIT_CNT_IEN]) ||
                       (updFlag_reg && ctrl2_reg[`BIT_UPD_IEN]));
      end
   end

   assign regRdData = rdData_reg;
   assign intN      = intN_reg;

endmodule // rtc_core

//--- core/rtc_regs.vh
// register map, field positions and reset values of the rtc core
// assumes inclusion by the rtc core and its self-checking bench only
`ifndef RTC_REGS_VH
`define RTC_REGS_VH

// register offsets
`define OFS_SEC      5'h00
`define OFS_MIN      5'h01
`define OFS_HOUR     5'h02
`define OFS_WEEK     5'h03
`define OFS_DATE     5'h04
`define OFS_MONTH    5'h05
`define OFS_YEAR     5'h06
`define OFS_ALM_MIN  5'h08
`define OFS_ALM_HOUR 5'h09
`define OFS_ALM_WD   5'h0a
`define OFS_PRE_LO   5'h0b
`define OFS_PRE_MID  5'h0c
`define OFS_CTRL1    5'h0d
`define OFS_FLAGS    5'h0e
`define OFS_CTRL2    5'h0f
`define OFS_TMR_RUN  5'h1b
`define OFS_CNT_LO   5'h1c
`define OFS_CNT_MID  5'h1d
`define OFS_CNT_HI   5'h1e
`define OFS_PRE_HI   5'h1f

// writable bits of each counter, the rest read zero
`define MASK_SEC     8'h7f
`define MASK_MIN     8'h7f
`define MASK_HOUR    8'h3f
`define MASK_WEEK    8'h7f
`define MASK_DATE    8'h3f
`define MASK_MONTH   8'h1f
`define MASK_YEAR    8'hff

// counter limits in bcd
`define MAX_SEC      8'h59
`define MAX_MIN      8'h59
`define MAX_HOUR     8'h23
`define MAX_MONTH    8'h12
`define MAX_YEAR     8'h99
`define DAYS_LONG    8'h31
`define DAYS_SHORT   8'h30
`define DAYS_FEB     8'h28
`define DAYS_FEB_LP  8'h29
`define MONTH_FEB    8'h02

// reset values
`define RST_ZERO     8'h00
`define RST_ONE      8'h01
`define RST_CTRL1    8'h02
`define RST_CTRL2    8'h40

// field positions
`define BIT_FLD_EN   7
`define BIT_WD_SEL   6
`define BIT_UPD_MIN  5
`define BIT_RUN_EN   4
`define BIT_UPD_FLG  5
`define BIT_CNT_FLG  4
`define BIT_ALM_FLG  3
`define BIT_LOW_HIST 1
`define BIT_SUP_DROP 0
`define BIT_UPD_IEN  5
`define BIT_CNT_IEN  4
`define BIT_ALM_IEN  3
`define BIT_PRE_CLR  0
`define BIT_HALT     7
`define BIT_RESTART  6

// divider chain: bit k toggles at 16384 Hz / 2**k
`define DIV_W        15
`define DIV_SUB_LO   5
`define DIV_SUB_HI   13
`define DIV_4096_MSB 2
`define DIV_64_MSB   8

// timer source codes
`define TSRC_4096    2'b00
`define TSRC_64      2'b01
`define TSRC_SEC     2'b10
`define TSRC_MIN     2'b11

`endif

//--- core/bcd_counter.v
// one packed bcd counter with load, limit and wrap value
// assumes loads are pre-masked and the limit is a valid bcd value
`timescale 1ns/1ps

module bcd_counter #(
   parameter [7:0] RST_VAL  = 8'h00,
   parameter [7:0] WRAP_VAL = 8'h00
) (
   // clock and reset
   input  wire       clk,
   input  wire       rstN,
   // control
   input  wire       load,
   input  wire [7:0] loadVal,
   input  wire       step,
   input  wire [7:0] maxVal,
   // state
   output wire [7:0] count,
   output wire       carry
);

   reg  [7:0] count_reg;
   reg  [7:0] count_next;

   // at or past the limit wraps, so an over-range load still recovers
   assign carry = step && (count_reg >= maxVal);
   assign count = count_reg;

   // decimal increment of the low digit with carry to the high digit
   always @* begin
      if (count_reg >= maxVal) begin
         count_next = WRAP_VAL;
      end else if (count_reg[3:0] == 4'h9) begin
         count_next = {count_reg[7:4] + 4'h1, 4'h0};
      end else begin
         count_next = count_reg + 8'h01;
      end
   end

   // load from the register port wins over a step
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         count_reg <= RST_VAL;
      end else if (load) begin
         count_reg <= loadVal;
      end else if (step) begin
         count_reg <= count_next;
      end
   end

endmodule // bcd_counter

//--- tb/rtc_core_monitor.sv
// checker of rtc_core port behaviour
// assumes bind to rtc_core, one clock domain
`timescale 1ns/1ps

module rtc_core_monitor (
   // clock and reset
   input wire       ref_clk,
   input wire       nrst,
   // oscillator and register port
   input wire       osc32kTick,
   input wire       regWr,
   input wire       regRd,
   input wire [4:0] regAddr,
   input wire [7:0] regWrData,
   input wire [7:0] regRdData,
   // interrupt pin
   input wire       intN
);
   default clocking mclk @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   // read data may only move after a read strobe
   rd_hold_a: assert property (!regRd [*2] |-> $stable(regRdData))
      else $error("read data moved without a read");
   unmapped_zero_a: assert property (regRd && regAddr == 5'h07 |-> ##2 regRdData == 8'h00)
      else $error("unmapped offset read nonzero");
   time_bit7_a: assert property (regRd && regAddr <= 5'h05 |-> ##2 !regRdData[7])
      else $error("time register bit 7 read one");
   hour_bits_a: assert property (regRd && (regAddr == 5'h02 || regAddr == 5'h04)
      |-> ##2 regRdData[7:6] == 2'b00)
      else $error("hour or date high bits read one");
   month_bits_a: assert property (regRd && regAddr == 5'h05 |-> ##2 regRdData[7:5] == 3'h0)
      else $error("month high bits read one");
   flag_zero_a: assert property (regRd && regAddr == 5'h0e
      |-> ##2 regRdData[7:6] == 2'b00 && !regRdData[2])
      else $error("flag fixed bits read one");
   tmr_ctl_zero_a: assert property (regRd && regAddr == 5'h1b |-> ##2 regRdData[5:0] == 6'h00)
      else $error("timer control low bits read one");
   // cleared flags or dropped enables release the pin within two edges
   flag_clr_a: assert property (regWr && regAddr == 5'h0e && regWrData == 8'h00 |-> ##2 intN)
      else $error("interrupt stayed low after flag clear");
   irq_off_a: assert property (regWr && regAddr == 5'h0f && regWrData[5:3] == 3'b000
      |-> ##2 intN)
      else $error("interrupt stayed low with enables off");
   reset_idle_a: assert property ($rose(nrst) |-> intN && regRdData == 8'h00)
      else $error("outputs not idle after reset");

   cover property ($fell(intN));
   cover property (regRd && regAddr == 5'h07);
   cover property (regWr && regAddr == 5'h0f && regWrData[0]);
endmodule // rtc_core_monitor

bind rtc_core rtc_core_monitor u_mon (
   .ref_clk(ref_clk), .nrst(nrst), .osc32kTick(osc32kTick), .regWr(regWr),
   .regRd(regRd), .regAddr(regAddr), .regWrData(regWrData),
   .regRdData(regRdData), .intN(intN)
);

//--- tb/rtc_host_model.sv
// host and oscillator model driving the rtc register port
// assumes callers enter its tasks just after a rising edge
`timescale 1ns/1ps

module rtc_host_model #(
   parameter TICK_GAP = 1
) (
   // clock
   input  wire        ref_clk,
   // oscillator tick
   output logic       osc32kTick,
   // register port
   output logic       regWr,
   output logic       regRd,
   output logic [4:0] regAddr,
   output logic [7:0] regWrData
);
   int tickCnt = 0;
   int gap = 0; // idle cycles added to the one after each access, for a slow host

   initial begin
      osc32kTick = 1'b0;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 5'h00;
      regWrData = 8'h00;
   end

   // oscillator ticks, every cycle when TICK_GAP is one to keep seconds short
   always @(posedge ref_clk) begin
      #1;
      tickCnt = (tickCnt + 1) % TICK_GAP;
      osc32kTick = (tickCnt == 0);
   end

   // one byte write; released lines show inverted junk, not stale data
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      regAddr = a;
      regWrData = d;
      regWr = 1'b1;
      @(posedge ref_clk);
      #1;
      regWr = 1'b0;
      regWrData = ~d;
      regAddr = ~a;
      repeat (1 + gap) begin
         @(posedge ref_clk);
         #1;
      end
   endtask

   // one byte read strobe; the bench picks up the answer
   task automatic rd(input logic [4:0] a);
      regAddr = a;
      regRd = 1'b1;
      @(posedge ref_clk);
      #1;
      regRd = 1'b0;
      regAddr = ~a;
      repeat (1 + gap) begin
         @(posedge ref_clk);
         #1;
      end
   endtask
endmodule // rtc_host_model

//--- tb/rtc_core_tb.sv
// self-checking bench of rtc_core: registers, countdown, calendar rollover
// assumes rtc_host_model drives the port; reads are checked from a queue
`timescale 1ns/1ps
`include "rtc_regs.vh"

module rtc_core_tb;
   logic        ref_clk;
   logic        nrst;
   wire         osc32kTick;
   wire         regWr;
   wire         regRd;
   wire  [4:0]  regAddr;
   wire  [7:0]  regWrData;
   wire  [7:0]  regRdData;
   wire         intN;
   int          fail_count = 0;
   int          comparisons = 0;
   int          n;
   logic [7:0]  expQ[$];
   logic        rdD1 = 1'b0;
   logic        rdD2 = 1'b0;
   logic [23:0] pre;
   // bytes year down to seconds: values set, then values one second later
   logic [55:0] setV [3] = '{56'h03022840235959, 56'h04022808235959, 56'h99123101235960};
   logic [55:0] expV [3] = '{56'h03030101000000, 56'h04022910000000, 56'h00010102000000};
   logic [7:0]  msk [7] = '{`MASK_SEC, `MASK_MIN, `MASK_HOUR, `MASK_WEEK,
                            `MASK_DATE, `MASK_MONTH, `MASK_YEAR};

   rtc_host_model #(.TICK_GAP(1)) u_host (.ref_clk(ref_clk), .osc32kTick(osc32kTick),
      .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWrData(regWrData));
   rtc_core #(.TMR_W(24)) u_dut (.ref_clk(ref_clk), .nrst(nrst), .osc32kTick(osc32kTick),
      .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWrData(regWrData),
      .regRdData(regRdData), .intN(intN));

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // read answer is settled two edges after the strobe
   always @(posedge ref_clk) begin
      rdD1 <= regRd;
      rdD2 <= rdD1;
   end
   always @(negedge ref_clk) begin
      if (rdD2 === 1'b1) begin
         cmpRd(expQ.pop_front(), regRdData);
      end
   end

   task automatic cmpRd(input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected at %0t: read %h, wanted %h", $time, g, e);
      end
   endtask

   task automatic chkInt(input logic e);
      comparisons++;
      if (intN !== e) begin
         fail_count++;
         $display("unexpected at %0t: interrupt pin %b", $time, intN);
      end
   endtask

   task automatic rng(input int v, input int lo, input int hi);
      comparisons++;
      if (v < lo || v > hi) begin
         fail_count++;
         $display("unexpected at %0t: event after %0d cycles", $time, v);
      end
   endtask

   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      expQ.push_back(e);
      u_host.rd(a);
   endtask

   task automatic waitInt(input int lim);
      n = 0;
      while (intN !== 1'b0 && n < lim) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (n >= lim) begin
         fail_count++;
         $display("unexpected at %0t: interrupt never came", $time);
         results();
      end
   endtask

   task automatic results();
      $display("comparisons %0d, fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      nrst = 1'b0;
      n = $urandom(18);
      repeat (8) @(posedge ref_clk);
      #1;
      nrst = 1'b1;
      // reset values; flags keep on a written one
      rd(`OFS_WEEK, `RST_ONE);
      rd(`OFS_CTRL1, `RST_CTRL1);
      rd(`OFS_FLAGS, 8'h03);
      u_host.wr(`OFS_FLAGS, 8'hfe);
      rd(`OFS_FLAGS, 8'h02);
      u_host.wr(`OFS_FLAGS, 8'h00);
      rd(`OFS_FLAGS, 8'h00);
      // fixed-zero bits drop writes
      for (int i = 0; i < 7; i++) begin
         u_host.wr(i[4:0], i == 3 ? 8'h40 : 8'hff);
         rd(i[4:0], i == 3 ? 8'h40 : msk[i]);
      end
      // unmapped and read-only places refuse writes
      u_host.wr(5'h07, 8'($urandom));
      rd(5'h07, 8'h00);
      u_host.wr(`OFS_CNT_LO, 8'($urandom));
      rd(`OFS_CNT_LO, 8'h00);
      // random preset reads back; halted restart copies it to the live count
      pre = 24'($urandom);
      u_host.wr(`OFS_PRE_LO, pre[7:0]);
      u_host.wr(`OFS_PRE_MID, pre[15:8]);
      u_host.wr(`OFS_PRE_HI, pre[23:16]);
      rd(`OFS_PRE_LO, pre[7:0]);
      rd(`OFS_PRE_MID, pre[15:8]);
      rd(`OFS_PRE_HI, pre[23:16]);
      u_host.wr(`OFS_TMR_RUN, 8'hff);
      rd(`OFS_TMR_RUN, 8'hc0);
      rd(`OFS_CNT_LO, pre[7:0]);
      rd(`OFS_CNT_MID, pre[15:8]);
      rd(`OFS_CNT_HI, pre[23:16]);
      u_host.wr(`OFS_TMR_RUN, 8'h00);
      // countdown of two on both fast sources, slow host on the second
      u_host.wr(`OFS_PRE_LO, 8'h02);
      u_host.wr(`OFS_PRE_MID, 8'h00);
      u_host.wr(`OFS_PRE_HI, 8'h00);
      u_host.wr(`OFS_CTRL2, 8'h10);
      for (int s = 0; s < 2; s++) begin
         u_host.gap = 2 * s;
         u_host.wr(`OFS_CTRL1, 8'h10 | s[7:0]);
         waitInt(1200);
         rng(n, s ? 504 : 0, s ? 1030 : 20);
         rd(`OFS_FLAGS, 8'h10);
         rd(`OFS_CNT_LO, 8'h00);
         u_host.wr(`OFS_FLAGS, 8'h00);
         chkInt(1'b1);
         u_host.wr(`OFS_CTRL1, 8'h00);
      end
      // alarm on 00:00 of weekday 02
      u_host.gap = 0;
      u_host.wr(`OFS_ALM_MIN, 8'h80);
      u_host.wr(`OFS_ALM_HOUR, 8'h80);
      u_host.wr(`OFS_ALM_WD, 8'h82);
      rd(`OFS_ALM_WD, 8'h82);
      // preset of one: second and minute sources both end on the update
      u_host.wr(`OFS_PRE_LO, 8'h01);
      // one second update per row; divider cleared so its timing is exact
      for (int r = 0; r < 3; r++) begin
         for (int i = 6; i >= 0; i--) begin
            u_host.wr(i[4:0], setV[r][8*i +: 8]);
         end
         u_host.wr(`OFS_CTRL1, {6'h04, r == 1 ? 2'b11 : 2'b10});
         u_host.wr(`OFS_CTRL2, 8'h29);
         waitInt(33000);
         rng(n, 32700, 32800);
         for (int i = 0; i < 7; i++) begin
            rd(i[4:0], expV[r][8*i +: 8]);
         end
         rd(`OFS_FLAGS, r == 2 ? 8'h38 : 8'h30);
         u_host.wr(`OFS_CTRL2, 8'h00);
         chkInt(1'b1);
         u_host.wr(`OFS_FLAGS, 8'h00);
         u_host.wr(`OFS_CTRL1, 8'h00);
      end
      results();
   end
endmodule // rtc_core_tb
